// File: hw/dtp_defines.svh
// Offsets, field positions, codes and reset values of the timer pair.
// Assumes inclusion by bare name from every design file that needs it.
// Function
// - Counter A equals compare A raises irq A
// - Cascade: joint match raises irq B only
// - Counters reset to zero, read-only bytes
// - Compare registers have no reset value
// - Discrete A clears on stop, match, overflow
// - Discrete B clears on stop, match, overflow
// - Cascade clears both on stop, joint events
// - Carrier A clears on stop, match, overflow
// - Carrier B clears on compare B, B-high
// - PWM B clears on B-high match, overflow
// - PWM A clears on stop, match, overflow
// - Run bit 7: zero stops and clears
// - Clock select picks six count sources for A, three for B
// - Edge select: rising or both edges
// - Both edges only in PWM mode
// - Joint mode decoded from both controls
// - Cascade ignores run A, B drives A
// - Bit 0 enables the output of its own timer, A or B
// - Control register resets to zero
// - PWM A output toggles on match, overflow
// - Cascade run B starts, stops both
`ifndef DTP_DEFINES_SVH
`define DTP_DEFINES_SVH

`define DTP_ADDR_W      18
`define DTP_IDX_W       16
`define DTP_IDX_CMP_A   16'hFF40
`define DTP_IDX_CMP_B   16'hFF41
`define DTP_IDX_CMP_BH  16'hFF42
`define DTP_IDX_CNT_A   16'hFF43
`define DTP_IDX_CNT_B   16'hFF44
`define DTP_IDX_CTRL_A  16'hFF4D
`define DTP_IDX_CTRL_B  16'hFF4E

`define DTP_BIT_RUN     7
`define DTP_BIT_EDGE    6
`define DTP_CSEL_HI     5
`define DTP_CSEL_LO     3
`define DTP_MODE_HI     2
`define DTP_MODE_LO     1
`define DTP_BIT_OE      0

`define DTP_CTRL_RESET  8'h00
`define DTP_CNT_RESET   8'h00
`define DTP_CNT_MAX     8'hFF
`define DTP_WORD_ZERO   32'h0000_0000

`define DTP_CS_MAIN     3'h0
`define DTP_CS_DIV8     3'h1
`define DTP_CS_DIV128   3'h2
`define DTP_CS_SUB      3'h3
`define DTP_CS_BMATCH   3'h4
`define DTP_CS_BOUT     3'h5
`define DTP_CSB_MAIN    3'h0
`define DTP_CSB_DIV4    3'h1

`define DTP_JM_DISCRETE 4'h0
`define DTP_JM_CASCADE  4'h5
`define DTP_JM_CARRIER  4'h3
`define DTP_JM_ADIS_BPW 4'h2
`define DTP_JM_BOTH_PWM 4'hA
`define DTP_JM_APW_BDIS 4'h8

`define DTP_DIV_W       7
`define DTP_TAP_DIV4    1
`define DTP_TAP_DIV8    2
`define DTP_TAP_DIV128  6
`define DTP_NUM_TAPS    3

`endif

// File: hw/dtp_pkg.sv
// Types shared by the timer pair modules.
// Assumes the defines header is compiled alongside.
package dtp_pkg;

  typedef enum logic [2:0] {
    DTP_DISCRETE     = 3'b000,
    DTP_CASCADE      = 3'b001,
    DTP_CARRIER      = 3'b010,
    DTP_A_DIS_B_PWM  = 3'b011,
    DTP_BOTH_PWM     = 3'b100,
    DTP_A_PWM_B_DIS  = 3'b101,
    DTP_PROHIBITED   = 3'b110
  } dtp_mode_type;

  // Index 0: main/4, 1: main/8, 2: main/128
  typedef struct packed {
    logic [2:0] rise;
    logic [2:0] fall;
  } dtp_edge_type;

endpackage

// File: hw/dtp_clk_div.sv
// Free-running prescaler giving edge pulses of divided main clocks.
// Assumes pclk is the main clock; pulses last one pclk cycle.
`timescale 1ns/10ps
`default_nettype none
`include "dtp_defines.svh"

module dtp_clk_div (
  input  wire logic                pclk,
  input  wire logic                presetn,
  output dtp_pkg::dtp_edge_type    edges
);

  logic [`DTP_DIV_W-1:0]   div_reg;
  logic [`DTP_NUM_TAPS-1:0] rise_next;
  logic [`DTP_NUM_TAPS-1:0] fall_next;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 1'b1;
    end
  end

  genvar i;
  generate
    for (i = 0; i < `DTP_NUM_TAPS; i++) begin : g_tap
      localparam int TAP = (i == 0) ? `DTP_TAP_DIV4 :
                           (i == 1) ? `DTP_TAP_DIV8 : `DTP_TAP_DIV128;
      // Pulse in the cycle the tap bit flips, so level and pulse agree
      assign rise_next[i] = ~div_reg[TAP] & (&div_reg[TAP-1:0]);
      assign fall_next[i] = div_reg[TAP] & (&div_reg[TAP-1:0]);
    end
  endgenerate

  // One process owns the whole edge struct
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edges <= '0;
    end else begin
      edges.rise <= rise_next;
      edges.fall <= fall_next;
    end
  end

endmodule // dtp_clk_div
`default_nettype wire

// File: hw/dtp_timer_pair.sv
// Pair of 8-bit timers A and B with APB register access.
// Assumes an APB master on pclk; sub_clk and ext_count_in are synchronous.
//
// Chosen here: the APB slave port.
`timescale 1ns/10ps
`default_nettype none
`include "dtp_defines.svh"

module dtp_timer_pair (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [`DTP_ADDR_W-1:0]  paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic                    sub_clk,
  input  wire logic                    ext_count_in,
  output logic                         match_irq_a,
  output logic                         match_irq_b,
  output logic                         timer_a_out,
  output logic                         timer_b_out
);

  logic [7:0]             mode_ctrl_a_reg;
  logic [7:0]             mode_ctrl_b_reg;
  logic [7:0]             compare_a_reg;
  logic [7:0]             compare_b_reg;
  logic [7:0]             compare_b_high_reg;
  logic [7:0]             counter_a_reg;
  logic [7:0]             counter_b_reg;
  logic                   out_a_reg;
  logic                   out_b_reg;
  logic                   sub_prev_reg;
  logic                   ext_prev_reg;
  logic                   bout_prev_reg;
  dtp_pkg::dtp_edge_type  div_edges;
  dtp_pkg::dtp_mode_type  mode;
  logic [`DTP_IDX_W-1:0]  idx;
  logic                   aligned;
  logic                   mapped;
  logic [7:0]             rd_byte;
  logic                   wr_en;
  logic                   a_pwm;
  logic                   b_pwm;
  logic                   cascade;
  logic                   run_a;
  logic                   run_b;
  logic                   rise_a;
  logic                   fall_a;
  logic                   rise_b;
  logic                   tick_a;
  logic                   tick_b;
  logic                   eq_a;
  logic                   eq_b;
  logic                   eq_bh;
  logic                   max_a;
  logic                   max_b;
  logic                   match_a_evt;
  logic                   ovf_a_evt;
  logic                   clr_b_evt;
  logic                   match_b_evt;
  logic                   joint_evt;
  logic [2:0]             csel_a;
  logic [2:0]             csel_b;

  dtp_clk_div u_div (
    .pclk    (pclk),
    .presetn (presetn),
    .edges   (div_edges)
  );

  // APB slave: one wait-free access phase after every setup
  assign idx     = paddr[`DTP_ADDR_W-1:2];
  assign aligned = (paddr[1:0] == 2'h0);
  assign wr_en   = psel & penable & pready & pwrite & mapped;

  always_comb begin
    mapped  = aligned;
    rd_byte = 8'h00;
    case (idx)
      `DTP_IDX_CMP_A:  rd_byte = compare_a_reg;
      `DTP_IDX_CMP_B:  rd_byte = compare_b_reg;
      `DTP_IDX_CMP_BH: rd_byte = compare_b_high_reg;
      `DTP_IDX_CNT_A:  rd_byte = counter_a_reg;
      `DTP_IDX_CNT_B:  rd_byte = counter_b_reg;
      `DTP_IDX_CTRL_A: rd_byte = mode_ctrl_a_reg;
      `DTP_IDX_CTRL_B: rd_byte = mode_ctrl_b_reg;
      default:         mapped  = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= `DTP_WORD_ZERO;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      if (psel & ~penable) begin
        prdata <= mapped ? {24'h000000, rd_byte} : `DTP_WORD_ZERO;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_ctrl_a_reg <= `DTP_CTRL_RESET;
      mode_ctrl_b_reg <= `DTP_CTRL_RESET;
    end else if (wr_en) begin
      if (idx == `DTP_IDX_CTRL_A) mode_ctrl_a_reg <= pwdata[7:0];
      if (idx == `DTP_IDX_CTRL_B) mode_ctrl_b_reg <= pwdata[7:0];
    end
  end

  // No reset: software loads them before use
  always_ff @(posedge pclk) begin
    if (wr_en && idx == `DTP_IDX_CMP_A)  compare_a_reg      <= pwdata[7:0];
    if (wr_en && idx == `DTP_IDX_CMP_B)  compare_b_reg      <= pwdata[7:0];
    if (wr_en && idx == `DTP_IDX_CMP_BH) compare_b_high_reg <= pwdata[7:0];
  end

  // Joint mode
  always_comb begin
    case ({mode_ctrl_a_reg[`DTP_MODE_HI:`DTP_MODE_LO],
           mode_ctrl_b_reg[`DTP_MODE_HI:`DTP_MODE_LO]})
      `DTP_JM_DISCRETE: mode = dtp_pkg::DTP_DISCRETE;
      `DTP_JM_CASCADE:  mode = dtp_pkg::DTP_CASCADE;
      `DTP_JM_CARRIER:  mode = dtp_pkg::DTP_CARRIER;
      `DTP_JM_ADIS_BPW: mode = dtp_pkg::DTP_A_DIS_B_PWM;
      `DTP_JM_BOTH_PWM: mode = dtp_pkg::DTP_BOTH_PWM;
      `DTP_JM_APW_BDIS: mode = dtp_pkg::DTP_A_PWM_B_DIS;
      default:          mode = dtp_pkg::DTP_PROHIBITED;
    endcase
  end

  assign cascade = (mode == dtp_pkg::DTP_CASCADE);
  assign a_pwm   = (mode == dtp_pkg::DTP_BOTH_PWM) ||
                   (mode == dtp_pkg::DTP_A_PWM_B_DIS);
  assign b_pwm   = (mode == dtp_pkg::DTP_BOTH_PWM) ||
                   (mode == dtp_pkg::DTP_A_DIS_B_PWM);
  assign run_b   = mode_ctrl_b_reg[`DTP_BIT_RUN];
  // Run A is ignored in cascade; run B governs both
  assign run_a   = cascade ? run_b : mode_ctrl_a_reg[`DTP_BIT_RUN];
  assign csel_a  = mode_ctrl_a_reg[`DTP_CSEL_HI:`DTP_CSEL_LO];
  assign csel_b  = mode_ctrl_b_reg[`DTP_CSEL_HI:`DTP_CSEL_LO];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sub_prev_reg  <= 1'b0;
      ext_prev_reg  <= 1'b0;
      bout_prev_reg <= 1'b0;
    end else begin
      sub_prev_reg  <= sub_clk;
      ext_prev_reg  <= ext_count_in;
      bout_prev_reg <= out_b_reg;
    end
  end

  // Timer B source; main clock has no falling edge inside pclk
  always_comb begin
    case (csel_b)
      `DTP_CSB_MAIN: rise_b = 1'b1;
      `DTP_CSB_DIV4: rise_b = div_edges.rise[0];
      default:       rise_b = ext_count_in & ~ext_prev_reg;
    endcase
  end

  assign tick_b = run_b & rise_b & (mode != dtp_pkg::DTP_PROHIBITED);
  assign eq_b   = (counter_b_reg == compare_b_reg);
  assign eq_bh  = (counter_b_reg == compare_b_high_reg);
  assign max_b  = (counter_b_reg == `DTP_CNT_MAX);
  assign eq_a   = (counter_a_reg == compare_a_reg);
  assign max_a  = (counter_a_reg == `DTP_CNT_MAX);
  assign joint_evt = cascade & tick_b & ((eq_a & eq_b) | (max_a & max_b));

  // Timer A source
  always_comb begin
    case (csel_a)
      `DTP_CS_MAIN: begin
        rise_a = 1'b1;
        fall_a = 1'b0;
      end
      `DTP_CS_DIV8: begin
        rise_a = div_edges.rise[1];
        fall_a = div_edges.fall[1];
      end
      `DTP_CS_DIV128: begin
        rise_a = div_edges.rise[2];
        fall_a = div_edges.fall[2];
      end
      `DTP_CS_SUB: begin
        rise_a = sub_clk & ~sub_prev_reg;
        fall_a = ~sub_clk & sub_prev_reg;
      end
      `DTP_CS_BMATCH: begin
        rise_a = match_b_evt;
        fall_a = 1'b0;
      end
      `DTP_CS_BOUT: begin
        rise_a = out_b_reg & ~bout_prev_reg;
        fall_a = ~out_b_reg & bout_prev_reg;
      end
      default: begin
        rise_a = 1'b0;
        fall_a = 1'b0;
      end
    endcase
  end

  always_comb begin
    if (cascade) begin
      // Carry out of B is A's count clock
      tick_a = tick_b & max_b & ~joint_evt;
    end else begin
      tick_a = run_a & (mode != dtp_pkg::DTP_PROHIBITED) &
               (rise_a | (fall_a & a_pwm &
                mode_ctrl_a_reg[`DTP_BIT_EDGE]));
    end
  end

  assign match_a_evt = ~cascade & tick_a & eq_a;
  assign ovf_a_evt   = ~cascade & tick_a & max_a & ~eq_a;

  always_comb begin
    case (mode)
      dtp_pkg::DTP_CASCADE: begin
        clr_b_evt   = joint_evt;
        match_b_evt = tick_b & eq_a & eq_b;
      end
      dtp_pkg::DTP_CARRIER: begin
        clr_b_evt   = tick_b & (eq_b | eq_bh);
        match_b_evt = tick_b & eq_b;
      end
      dtp_pkg::DTP_BOTH_PWM, dtp_pkg::DTP_A_DIS_B_PWM: begin
        clr_b_evt   = tick_b & (eq_bh | max_b);
        match_b_evt = tick_b & eq_b;
      end
      default: begin
        clr_b_evt   = tick_b & (eq_b | max_b);
        match_b_evt = tick_b & eq_b;
      end
    endcase
  end

  // Counter A: wrap at FFH equals overflow clear in 8 bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter_a_reg <= `DTP_CNT_RESET;
    end else if (!run_a) begin
      counter_a_reg <= `DTP_CNT_RESET;
    end else if (joint_evt || match_a_evt) begin
      counter_a_reg <= `DTP_CNT_RESET;
    end else if (tick_a) begin
      counter_a_reg <= counter_a_reg + 8'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter_b_reg <= `DTP_CNT_RESET;
    end else if (!run_b) begin
      counter_b_reg <= `DTP_CNT_RESET;
    end else if (clr_b_evt) begin
      counter_b_reg <= `DTP_CNT_RESET;
    end else if (tick_b) begin
      counter_b_reg <= counter_b_reg + 8'h01;
    end
  end

  // Output waveforms
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_a_reg <= 1'b0;
    end else if (!run_a) begin
      out_a_reg <= 1'b0;
    end else if (match_a_evt || (a_pwm && ovf_a_evt)) begin
      out_a_reg <= ~out_a_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_b_reg <= 1'b0;
    end else if (!run_b) begin
      out_b_reg <= 1'b0;
    end else if (b_pwm) begin
      // Low until compare B, high until the B-high match ends the period
      if (clr_b_evt) out_b_reg <= 1'b0;
      else if (match_b_evt) out_b_reg <= 1'b1;
    end else if (cascade ? joint_evt : clr_b_evt & ~max_b) begin
      out_b_reg <= ~out_b_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      match_irq_a <= 1'b0;
      match_irq_b <= 1'b0;
      timer_a_out <= 1'b0;
      timer_b_out <= 1'b0;
    end else begin
      match_irq_a <= match_a_evt;
      match_irq_b <= match_b_evt;
      timer_a_out <= out_a_reg & mode_ctrl_a_reg[`DTP_BIT_OE];
      timer_b_out <= out_b_reg & mode_ctrl_b_reg[`DTP_BIT_OE];
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence a_pwm_edge_s;
    a_pwm && run_a && (match_a_evt || ovf_a_evt);
  endsequence

  sequence casc_stop_s;
    cascade && !run_b;
  endsequence

  irq_a_match_a: assert property (
    (tick_a && eq_a && !cascade) |=> match_irq_a && counter_a_reg == 8'h00)
    else $error("match on A gave no irq A or no clear");
  casc_no_irq_a: assert property (cascade |=> !match_irq_a)
    else $error("irq A raised in cascade mode");
  disc_ovf_a: assert property (
    (mode == dtp_pkg::DTP_DISCRETE && tick_a && max_a) |=>
    counter_a_reg == 8'h00)
    else $error("counter A did not clear on overflow");
  disc_match_b_a: assert property (
    (mode == dtp_pkg::DTP_DISCRETE && tick_b && eq_b) |=>
    counter_b_reg == 8'h00 && match_irq_b)
    else $error("counter B match did not clear and flag");
  casc_joint_clr_a: assert property (
    (cascade && tick_b && eq_a && eq_b) |=>
    counter_a_reg == 8'h00 && counter_b_reg == 8'h00 && match_irq_b)
    else $error("joint match did not clear both counters");
  carr_high_clr_a: assert property (
    (mode == dtp_pkg::DTP_CARRIER && tick_b && eq_bh) |=>
    counter_b_reg == 8'h00)
    else $error("carrier B did not clear on high width match");
  pwm_b_period_a: assert property (
    (b_pwm && tick_b && eq_bh) |=> counter_b_reg == 8'h00 && !out_b_reg)
    else $error("PWM B period end wrong");
  stop_a_clr_a: assert property (
    (!cascade && !mode_ctrl_a_reg[`DTP_BIT_RUN]) |=> counter_a_reg == 8'h00)
    else $error("counter A not cleared while stopped");
  edge_only_pwm_a: assert property (
    (!a_pwm && !cascade && fall_a && !rise_a) |=> $stable(counter_a_reg))
    else $error("falling edge counted outside PWM");
  pwm_a_toggle: assert property (a_pwm_edge_s |=> $changed(out_a_reg))
    else $error("PWM A output did not toggle");
  casc_stop_both_a: assert property (
    casc_stop_s |=> counter_a_reg == 8'h00 && counter_b_reg == 8'h00)
    else $error("cascade stop did not clear both counters");
  inc_one_a: assert property (
    (tick_a && !eq_a && !max_a && !joint_evt) |=>
    counter_a_reg == $past(counter_a_reg) + 8'h01)
    else $error("counter A did not step by one");
  oe_gate_a: assert property (
    !mode_ctrl_a_reg[`DTP_BIT_OE] |=> !timer_a_out)
    else $error("timer A output active while disabled");

endmodule // dtp_timer_pair
`default_nettype wire

// File: testbench/dtp_timer_pair_tb.sv
// Self-checking bench for the timer pair: APB access, modes, count clocks.
// Assumes the design files and the defines header are compiled first.
`timescale 1ns/10ps
`default_nettype none
`include "dtp_defines.svh"
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin \
  miscompares++; $display("Error at %0t: got %0h expected %0h", \
  $time, got, exp); end end

module dtp_timer_pair_tb;
  logic                   pclk;
  logic                   presetn;
  logic                   psel;
  logic                   penable;
  logic                   pwrite;
  logic [`DTP_ADDR_W-1:0] paddr;
  logic [31:0]            pwdata;
  logic [31:0]            prdata;
  logic                   pready;
  logic                   pslverr;
  logic [2:0]             sdiv = 3'h0;
  logic                   match_irq_a;
  logic                   match_irq_b;
  logic                   timer_a_out;
  logic                   timer_b_out;
  logic [3:0]             sigs;
  logic [31:0]            rd;
  logic                   err;
  logic [7:0]             ca;
  int                     miscompares;
  int                     checks;
  int                     cyc = 0;
  int                     seed;
  int                     n;
  int                     m;
  int                     per;
  int                     hi;
  int                     i;
  int                     div_tab [7] = '{1, 8, 128, 8, 4, 8, 8};
  logic [2:0]             cs_tab  [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4,
                                          3'h5, 3'h3};

  assign sigs = {timer_b_out, timer_a_out, match_irq_b, match_irq_a};

  dtp_timer_pair dut (
    .pclk         (pclk),
    .presetn      (presetn),
    .psel         (psel),
    .penable      (penable),
    .pwrite       (pwrite),
    .paddr        (paddr),
    .pwdata       (pwdata),
    .prdata       (prdata),
    .pready       (pready),
    .pslverr      (pslverr),
    .sub_clk      (sdiv[2]),
    .ext_count_in (sdiv[1]),
    .match_irq_a  (match_irq_a),
    .match_irq_b  (match_irq_b),
    .timer_a_out  (timer_a_out),
    .timer_b_out  (timer_b_out)
  );

  initial begin
    pclk = 1'h0;
    forever #2.5 pclk = ~pclk;
  end

  // Subclock period 8 cycles, external input rises every 4
  always @(posedge pclk) begin
    sdiv <= sdiv + 3'h1;
    cyc  <= cyc + 1;
    if (cyc == 90000) begin
      miscompares++;
      results();
    end
  end

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [15:0] idx,
                     input logic [7:0] wd);
    @(posedge pclk);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= wr;
    paddr   <= {idx, 2'h0};
    pwdata  <= {24'h000000, wd};
    @(posedge pclk);
    penable <= 1'h1;
    // Only the bench timeout ends this wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic rchk(input logic [15:0] idx, input logic [7:0] exp);
    apb(1'h0, idx, 8'h00);
    `CHK(rd, {24'h000000, exp})
  endtask

  function automatic logic [7:0] ctl(input logic run, input logic edg,
    input logic [2:0] cs, input logic [1:0] md, input logic oe);
    return {run, edg, cs, md, oe};
  endfunction

  // Stop, configure, then start: a live reconfigure could glitch
  task automatic cfg(input logic [7:0] a, input logic [7:0] b);
    apb(1'h1, `DTP_IDX_CTRL_A, a & 8'h7F);
    apb(1'h1, `DTP_IDX_CTRL_B, b & 8'h7F);
    apb(1'h1, `DTP_IDX_CTRL_A, a);
    apb(1'h1, `DTP_IDX_CTRL_B, b);
  endtask

  // Rise-to-rise spacing and high time of one watched output
  task automatic gap(input int w, input int lim);
    logic p;
    int   k;
    int   r1;
    p   = 1'h1;
    per = 0;
    hi  = 0;
    r1  = -1;
    for (k = 0; k < lim && per == 0; k++) begin
      @(posedge pclk);
      #1;
      if (sigs[w] === 1'h1 && p !== 1'h1) begin
        if (r1 >= 0)
          per = k - r1;
        else
          r1 = k;
      end
      if (r1 >= 0 && per == 0 && sigs[w] === 1'h1)
        hi++;
      p = sigs[w];
    end
  endtask

  initial begin
    seed    = 32'h0049;
    presetn = 1'h0;
    psel    = 1'h0;
    penable = 1'h0;
    pwrite  = 1'h0;
    paddr   = 18'h00000;
    pwdata  = 32'h00000000;
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    #1;
    `CHK(sigs, 4'h0)
    rchk(`DTP_IDX_CTRL_A, 8'h00);
    rchk(`DTP_IDX_CTRL_B, 8'h00);
    rchk(`DTP_IDX_CNT_A, 8'h00);
    rchk(`DTP_IDX_CNT_B, 8'h00);
    apb(1'h0, 16'h0010, 8'h00);
    `CHK({err, rd}, 33'h100000000)
    for (i = 0; i < 3; i++) begin
      n = $random(seed);
      apb(1'h1, `DTP_IDX_CMP_A + i[15:0], n[7:0]);
      rchk(`DTP_IDX_CMP_A + i[15:0], n[7:0]);
    end
    apb(1'h1, `DTP_IDX_CNT_A, 8'h5A);
    rchk(`DTP_IDX_CNT_A, 8'h00);
    apb(1'h1, `DTP_IDX_CMP_B, 8'h03);
    // Last entry: both edges asked for outside PWM
    for (i = 0; i < 7; i++) begin
      n = 2 + ($unsigned($random(seed)) % 8);
      apb(1'h1, `DTP_IDX_CTRL_A, 8'h00);
      apb(1'h1, `DTP_IDX_CMP_A, n[7:0]);
      ca = ctl(1'h1, i == 6, cs_tab[i], 2'h0, 1'h1);
      cfg(ca, 8'h81);
      rchk(`DTP_IDX_CTRL_A, ca);
      gap(0, 6000);
      `CHK(per, (n + 1) * div_tab[i])
      `CHK(hi, 1)
    end
    apb(1'h1, `DTP_IDX_CTRL_A, 8'h00);
    rchk(`DTP_IDX_CNT_A, 8'h00);
    m = 2 + ($unsigned($random(seed)) % 8);
    apb(1'h1, `DTP_IDX_CMP_B, m[7:0]);
    cfg(8'h00, ctl(1'h1, 1'h0, 3'h2, 2'h0, 1'h0));
    gap(1, 6000);
    `CHK(per, (m + 1) * 4)
    apb(1'h1, `DTP_IDX_CMP_A, 8'h01);
    cfg(ctl(1'h0, 1'h0, 3'h0, 2'h1, 1'h0), ctl(1'h1, 1'h0, 3'h0, 2'h1, 1'h0));
    gap(0, 600);
    `CHK(per, 0)
    gap(1, 6000);
    `CHK(per, 256 + m + 1)
    repeat (258) @(posedge pclk);
    apb(1'h1, `DTP_IDX_CTRL_B, 8'h02);
    rchk(`DTP_IDX_CNT_A, 8'h00);
    rchk(`DTP_IDX_CNT_B, 8'h00);
    for (i = 0; i < 2; i++) begin
      n = 2 + ($unsigned($random(seed)) % 8);
      apb(1'h1, `DTP_IDX_CTRL_A, 8'h00);
      apb(1'h1, `DTP_IDX_CMP_A, n[7:0]);
      cfg(ctl(1'h1, i[0], 3'h3, 2'h2, 1'h1), 8'h00);
      gap(2, 6000);
      `CHK(hi, (n + 1) * (8 >> i))
      `CHK(per, 2 * (n + 1) * (8 >> i))
    end
    cfg(ctl(1'h1, 1'h0, 3'h0, 2'h2, 1'h0), 8'h00);
    gap(2, 400);
    `CHK(per, 0)
    `CHK(timer_a_out, 1'h0)
    m = 2 + ($unsigned($random(seed)) % 8);
    n = m + 2 + ($unsigned($random(seed)) % 8);
    apb(1'h1, `DTP_IDX_CMP_B, m[7:0]);
    apb(1'h1, `DTP_IDX_CMP_BH, n[7:0]);
    cfg(8'h00, ctl(1'h1, 1'h0, 3'h0, 2'h2, 1'h1));
    gap(1, 600);
    `CHK(per, n + 1)
    gap(3, 600);
    `CHK(per, n + 1)
    `CHK(hi, n - m)
    apb(1'h1, `DTP_IDX_CMP_A, n[7:0]);
    apb(1'h1, `DTP_IDX_CMP_BH, 8'hC8);
    cfg(ctl(1'h1, 1'h0, 3'h0, 2'h0, 1'h0), ctl(1'h1, 1'h0, 3'h0, 2'h3, 1'h0));
    gap(1, 600);
    `CHK(per, m + 1)
    gap(0, 600);
    `CHK(per, n + 1)
    apb(1'h1, `DTP_IDX_CMP_B, n[7:0]);
    apb(1'h1, `DTP_IDX_CMP_BH, m[7:0]);
    gap(1, 300);
    `CHK(per, 0)
    cfg(ctl(1'h1, 1'h0, 3'h0, 2'h3, 1'h0), ctl(1'h1, 1'h0, 3'h0, 2'h3, 1'h0));
    gap(0, 300);
    `CHK(per, 0)
    rchk(`DTP_IDX_CNT_A, 8'h00);
    results();
  end
endmodule // dtp_timer_pair_tb
`default_nettype wire
